// [core/adcs_top.sv]
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
// Functional notes
// - external inputs: 4 sample, 12 convert periods
// - temperature sensor: 46 sample, 12 convert
// - conversion runs autonomously after start
// - start pulse low-high-low begins conversion
// - busy high during conversion, then results valid
// - enable cleared powers converter down
// - 12-bit unsigned code, full scale FFF
// - alignment bit selects result placement
// - slope stored at 3FD5H, 3FD6H
// - offset stored at 3FD7H, 3FD8H
// - calibration readable only while mapping enabled
// - divider code gives divide 1 to 128
// - codes 000,110 route external; 111 refused
module adcs_top
  import adcs_pkg::*;
#(
  parameter logic [15:0] CAL_SLOPE = 16'h1000,
  parameter logic [11:0] CAL_TOS = 12'h000
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [11:0] adc_code,
  output adcs_analog_t analog,
  output logic conversion_busy_flag,
  output logic conversion_interrupt_flag
);

  adcs_state_t s_q;
  adcs_state_t s_d;

  logic req;
  logic wr;
  logic [7:0] wb;
  logic div_tick;
  logic [6:0] div_max;
  logic [5:0] sample_len;
  logic [2:0] src_sel;
  logic [2:0] new_src;
  logic start_now;
  logic start_fall;
  logic conv_done;
  logic [7:0] cal_byte;

  // bus request decode; writes land at the edge the master sees ack
  assign req = wb_cyc_i & wb_stb_i;
  assign wr = req & wb_we_i & s_q.ack & wb_sel_i[0];
  assign wb = wb_dat_i[7:0];

  // converter clock tick from power-of-two divider
  assign div_max = 7'((8'h01 << s_q.ctrl1[ADCS_C1_DIV_LSB +: 3]) - 8'h01);
  assign div_tick = (s_q.div_cnt >= div_max);

  // sampling length picked by the selected input
  assign src_sel = s_q.ctrl1[ADCS_C1_SRC_LSB +: 3];
  assign sample_len = (src_sel == ADCS_SRC_TEMP) ? ADCS_SAMPLE_TEMP : ADCS_SAMPLE_NORMAL;

  // start bit falling edge starts, rising edge aborts
  assign start_now = s_q.ctrl0[ADCS_C0_START];
  assign start_fall = s_q.start_prev & ~start_now;
  assign conv_done = (s_q.phase == ADCS_CONVERT) & div_tick & (s_q.phase_cnt == ADCS_CONVERT_LEN - 6'h01);

  // source write keeps old value when forbidden code is given
  assign new_src = (wb[ADCS_C1_SRC_LSB +: 3] == ADCS_SRC_FORBID) ? src_sel : wb[ADCS_C1_SRC_LSB +: 3];

  // calibration byte lookup, gated by mapping enable
  always_comb begin
    cal_byte = ADCS_RST_BYTE;
    if (s_q.optmap) begin
      if (s_q.cal_addr == ADCS_CAL_SLOPE_HI) begin
        cal_byte = CAL_SLOPE[15:8];
      end else if (s_q.cal_addr == ADCS_CAL_SLOPE_LO) begin
        cal_byte = CAL_SLOPE[7:0];
      end else if (s_q.cal_addr == ADCS_CAL_TOS_HI) begin
        cal_byte = CAL_TOS[11:4];
      end else if (s_q.cal_addr == ADCS_CAL_TOS_LO) begin
        cal_byte = {4'h0, CAL_TOS[3:0]};
      end
    end
  end

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.start_prev = start_now;

    // one-cycle ack, dropped the cycle after it was given
    s_d.ack = req & ~s_q.ack;
    s_d.rdata = 32'h0000_0000;
    if (req & ~s_q.ack & ~wb_we_i) begin
      if (wb_adr_i == ADCS_OFF_CTRL0) begin
        s_d.rdata[7:0] = s_q.ctrl0;
      end else if (wb_adr_i == ADCS_OFF_CTRL1) begin
        s_d.rdata[7:0] = s_q.ctrl1;
      end else if (wb_adr_i == ADCS_OFF_CTRL2) begin
        s_d.rdata[7:0] = s_q.ctrl2;
      end else if (wb_adr_i == ADCS_OFF_RES_HI) begin
        s_d.rdata[7:0] = s_q.res_hi;
      end else if (wb_adr_i == ADCS_OFF_RES_LO) begin
        s_d.rdata[7:0] = s_q.res_lo;
      end else if (wb_adr_i == ADCS_OFF_INTC) begin
        s_d.rdata[ADCS_IC_ENABLE] = s_q.int_enable;
        s_d.rdata[ADCS_IC_FLAG] = s_q.int_flag;
      end else if (wb_adr_i == ADCS_OFF_OPTMAP) begin
        s_d.rdata[0] = s_q.optmap;
      end else if (wb_adr_i == ADCS_OFF_CAL_ADDR) begin
        s_d.rdata[13:0] = s_q.cal_addr;
      end else if (wb_adr_i == ADCS_OFF_CAL_DATA) begin
        s_d.rdata[7:0] = cal_byte;
      end
    end

    // register writes; busy bit is read-only
    if (wr) begin
      if (wb_adr_i == ADCS_OFF_CTRL0) begin
        s_d.ctrl0 = {wb[7], s_q.ctrl0[ADCS_C0_BUSY], wb[5:0]};
      end else if (wb_adr_i == ADCS_OFF_CTRL1) begin
        s_d.ctrl1 = {new_src, wb[4:0]};
      end else if (wb_adr_i == ADCS_OFF_CTRL2) begin
        s_d.ctrl2 = {wb[7:6], 6'h00};
      end else if (wb_adr_i == ADCS_OFF_INTC) begin
        s_d.int_enable = wb[ADCS_IC_ENABLE];
        s_d.int_flag = s_q.int_flag & wb[ADCS_IC_FLAG];
      end else if (wb_adr_i == ADCS_OFF_OPTMAP) begin
        s_d.optmap = wb[0];
      end else if (wb_adr_i == ADCS_OFF_CAL_ADDR) begin
        s_d.cal_addr = wb_dat_i[13:0];
      end
    end

    // divider free-runs only inside a conversion
    if (s_q.phase == ADCS_IDLE || div_tick) begin
      s_d.div_cnt = ADCS_RST_DIV;
    end else begin
      s_d.div_cnt = 7'(s_q.div_cnt + 7'h01);
    end

    // conversion sequencer, independent of the bus
    case (s_q.phase)
      ADCS_IDLE: begin
        if (start_fall & s_q.ctrl0[ADCS_C0_PWR]) begin
          s_d.phase = ADCS_SAMPLE;
          s_d.phase_cnt = 6'h00;
        end
      end
      ADCS_SAMPLE: begin
        if (div_tick) begin
          if (s_q.phase_cnt == sample_len - 6'h01) begin
            s_d.phase = ADCS_CONVERT;
            s_d.phase_cnt = 6'h00;
          end else begin
            s_d.phase_cnt = 6'(s_q.phase_cnt + 6'h01);
          end
        end
      end
      ADCS_CONVERT: begin
        if (div_tick) begin
          s_d.phase_cnt = 6'(s_q.phase_cnt + 6'h01);
        end
        if (conv_done) begin
          s_d.phase = ADCS_IDLE;
          // result placement by alignment bit
          if (s_q.ctrl0[ADCS_C0_ALIGN]) begin
            s_d.res_hi = {4'h0, adc_code[11:8]};
            s_d.res_lo = adc_code[7:0];
          end else begin
            s_d.res_hi = adc_code[11:4];
            s_d.res_lo = {adc_code[3:0], 4'h0};
          end
          s_d.int_flag = 1'b1;
        end
      end
      default: begin
        s_d.phase = ADCS_IDLE;
      end
    endcase

    // rising start edge or power-off aborts
    if ((start_now & ~s_q.start_prev) | ~s_q.ctrl0[ADCS_C0_PWR]) begin
      s_d.phase = ADCS_IDLE;
      s_d.phase_cnt = 6'h00;
    end

    // busy mirrors the sequencer
    s_d.ctrl0[ADCS_C0_BUSY] = (s_d.phase != ADCS_IDLE);

    // analog side controls
    s_d.ana.power = s_q.ctrl0[ADCS_C0_PWR];
    s_d.ana.sample = (s_d.phase == ADCS_SAMPLE);
    s_d.ana.convert = (s_d.phase == ADCS_CONVERT);
    s_d.ana.temp_sensor_enable = s_q.ctrl2[ADCS_C2_TEMP_SENSOR_ENABLE];
    s_d.ana.low_current_conv_mode = s_q.ctrl2[ADCS_C2_LOWCUR];
    s_d.ana.route_external = s_q.ctrl0[ADCS_C0_PWR] &
      ((src_sel == ADCS_SRC_EXT_A) | (src_sel == ADCS_SRC_EXT_B));
    s_d.ana.external_channel_select = s_q.ctrl0[3:0];
    s_d.ana.input_source_select = src_sel;
    s_d.ana.reference_source_select = s_q.ctrl1[1:0];
  end

  // state register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from state flops
  assign wb_dat_o = s_q.rdata;
  assign wb_ack_o = s_q.ack;
  assign analog = s_q.ana;
  assign conversion_busy_flag = s_q.ctrl0[ADCS_C0_BUSY];
  assign conversion_interrupt_flag = s_q.int_flag;

endmodule : adcs_top

// [shared/adcs_pkg.sv]
package adcs_pkg;

  // register byte offsets
  localparam logic [7:0] ADCS_OFF_CTRL0 = 8'h00;
  localparam logic [7:0] ADCS_OFF_CTRL1 = 8'h04;
  localparam logic [7:0] ADCS_OFF_CTRL2 = 8'h08;
  localparam logic [7:0] ADCS_OFF_RES_HI = 8'h0C;
  localparam logic [7:0] ADCS_OFF_RES_LO = 8'h10;
  localparam logic [7:0] ADCS_OFF_INTC = 8'h14;
  localparam logic [7:0] ADCS_OFF_OPTMAP = 8'h18;
  localparam logic [7:0] ADCS_OFF_CAL_ADDR = 8'h1C;
  localparam logic [7:0] ADCS_OFF_CAL_DATA = 8'h20;

  // converter_control_0 field positions
  localparam int ADCS_C0_START = 7;
  localparam int ADCS_C0_BUSY = 6;
  localparam int ADCS_C0_PWR = 5;
  localparam int ADCS_C0_ALIGN = 4;
  // converter_control_1 field positions
  localparam int ADCS_C1_SRC_LSB = 5;
  localparam int ADCS_C1_DIV_LSB = 2;
  // converter_control_2 field positions
  localparam int ADCS_C2_TEMP_SENSOR_ENABLE = 7;
  localparam int ADCS_C2_LOWCUR = 6;
  // interrupt control field positions
  localparam int ADCS_IC_ENABLE = 0;
  localparam int ADCS_IC_FLAG = 1;

  // source select codes
  localparam logic [2:0] ADCS_SRC_EXT_A = 3'h0;
  localparam logic [2:0] ADCS_SRC_EXT_B = 3'h6;
  localparam logic [2:0] ADCS_SRC_TEMP = 3'h2;
  localparam logic [2:0] ADCS_SRC_FORBID = 3'h7;

  // phase lengths in converter clock periods
  localparam logic [5:0] ADCS_SAMPLE_NORMAL = 6'h04;
  localparam logic [5:0] ADCS_SAMPLE_TEMP = 6'h2E;
  localparam logic [5:0] ADCS_CONVERT_LEN = 6'h0C;

  // calibration words in mapped program memory
  localparam logic [13:0] ADCS_CAL_SLOPE_HI = 14'h3FD5;
  localparam logic [13:0] ADCS_CAL_SLOPE_LO = 14'h3FD6;
  localparam logic [13:0] ADCS_CAL_TOS_HI = 14'h3FD7;
  localparam logic [13:0] ADCS_CAL_TOS_LO = 14'h3FD8;

  // reset values
  localparam logic [7:0] ADCS_RST_BYTE = 8'h00;
  localparam logic [6:0] ADCS_RST_DIV = 7'h00;

  typedef enum logic [1:0] {
    ADCS_IDLE = 2'b00,
    ADCS_SAMPLE = 2'b01,
    ADCS_CONVERT = 2'b10
  } adcs_phase_t;

  // signals to the analog converter and sensor
  typedef struct packed {
    logic power;
    logic sample;
    logic convert;
    logic temp_sensor_enable;
    logic low_current_conv_mode;
    logic route_external;
    logic [3:0] external_channel_select;
    logic [2:0] input_source_select;
    logic [1:0] reference_source_select;
  } adcs_analog_t;

  // whole module state
  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] res_hi;
    logic [7:0] res_lo;
    logic int_enable;
    logic int_flag;
    logic optmap;
    logic [13:0] cal_addr;
    logic start_prev;
    adcs_phase_t phase;
    logic [6:0] div_cnt;
    logic [5:0] phase_cnt;
    logic ack;
    logic [31:0] rdata;
    adcs_analog_t ana;
  } adcs_state_t;

endpackage : adcs_pkg

// [testbench/adcs_checker.sv]
`timescale 1ns/1ns
module adcs_checker
  import adcs_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire adcs_analog_t analog,
  input wire logic conversion_busy_flag,
  input wire logic conversion_interrupt_flag
);
  // all checks on the one clock
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_busy_phase; conversion_busy_flag |-> (analog.sample || analog.convert); endproperty
  a_busy_phase: assert property (p_busy_phase) else $error("busy outside sample or convert");
  property p_off_idle; !analog.power |-> !conversion_busy_flag; endproperty
  a_off_idle: assert property (p_off_idle) else $error("busy while powered down");
  property p_off_quiet; !analog.power |-> !(analog.sample || analog.convert); endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("phase active while powered down");
  property p_route; analog.route_external == (analog.power && (analog.input_source_select == ADCS_SRC_EXT_A
    || analog.input_source_select == ADCS_SRC_EXT_B)); endproperty
  a_route: assert property (p_route) else $error("external routing wrong");
  property p_no_forbid; analog.input_source_select != ADCS_SRC_FORBID; endproperty
  a_no_forbid: assert property (p_no_forbid) else $error("forbidden source code taken");
  property p_done_flag; $fell(conversion_busy_flag) && analog.power |-> conversion_interrupt_flag; endproperty
  a_done_flag: assert property (p_done_flag) else $error("no request flag at end");
  property p_sample_conv; $fell(analog.sample) && analog.power |-> analog.convert; endproperty
  a_sample_conv: assert property (p_sample_conv) else $error("sampling not followed by convert");
  property p_conv_len; $rose(analog.convert) |-> analog.convert[*8]; endproperty
  a_conv_len: assert property (p_conv_len) else $error("convert phase too short");
  property p_start; $rose(conversion_busy_flag) |-> analog.sample && analog.power; endproperty
  a_start: assert property (p_start) else $error("run does not open with sampling");
endmodule : adcs_checker
bind adcs_top adcs_checker chk_u (.clk(clk), .reset(reset), .analog(analog),
  .conversion_busy_flag(conversion_busy_flag), .conversion_interrupt_flag(conversion_interrupt_flag));

// [testbench/adcs_analog_model.sv]
`timescale 1ns/1ns
module adcs_analog_model
  import adcs_pkg::*;
(
  input wire logic clk,
  input wire adcs_analog_t analog,
  input wire logic [11:0] level,
  output logic [11:0] adc_code
);
  logic [11:0] junk_q = 12'hA5A;
  // junk pattern changes every cycle outside a powered conversion
  always @(posedge clk) begin
    junk_q <= ~junk_q;
  end
  // 12-bit code only while powered and converting
  assign adc_code = (analog.power && analog.convert) ? level : junk_q;
endmodule : adcs_analog_model

// [testbench/testbench.sv]
`timescale 1ns/1ns
`define CMP(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; $display("Error %0t %h %h", $time, a, e); end end
module testbench;
  import adcs_pkg::*;
  logic clk = 0, reset = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rd;
  logic [11:0] level = 12'h000, v;
  logic [11:0] code;
  logic [31:0] dout;
  logic ack, busy, flag;
  adcs_analog_t ana;
  int bad_count = 0, checks = 0, cyc_n = 0, seed = 32'h0b5f2d3e, len, n, t;
  logic [3:0] sel = 4'h1, ch;
  logic [7:0] hi;
  logic [7:0] cal_rd [4];
  logic [11:0] tx;
  logic [7:0] cal_tab [4] = '{8'h0A, 8'hB9, 8'h40, 8'h07};
  logic [2:0] src_tab [3] = '{3'h0, 3'h6, 3'h2};
  adcs_top #(.CAL_SLOPE(16'h0AB9), .CAL_TOS(12'h407)) dut_u (.clk(clk), .reset(reset), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout),
    .wb_ack_o(ack), .adc_code(code), .analog(ana), .conversion_busy_flag(busy), .conversion_interrupt_flag(flag));
  adcs_analog_model far_u (.clk(clk), .analog(ana), .level(level), .adc_code(code));
  initial forever #25 clk = ~clk;
  // verdict and end of run
  task automatic summarize();
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dout;
    cyc <= 0;
    stb <= 0;
  endtask : wb
  // hang guard
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n > 30000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    reset <= 0;
    // reset values, unmapped place, calibration data read at address 0 while unmapped
    for (int k = 0; k < 10; k++) begin
      wb(1'b0, 8'(k * 4), 32'h0);
      `CMP(rd, 32'h0)
    end
    wb(1'b1, ADCS_OFF_CTRL1, 32'h0000_00E0);
    // write with byte lane 0 off must be ignored
    sel <= 4'h0;
    wb(1'b1, ADCS_OFF_CTRL1, 32'h0000_00FF);
    sel <= 4'h1;
    wb(1'b0, ADCS_OFF_CTRL1, 32'h0);
    `CMP(rd[7:5], 3'h0)
    `CMP(rd, 32'h0)
    wb(1'b1, ADCS_OFF_OPTMAP, 32'h1);
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, ADCS_OFF_CAL_ADDR, 32'(ADCS_CAL_SLOPE_HI + 14'(k)));
      wb(1'b0, ADCS_OFF_CAL_DATA, 32'h0);
      cal_rd[k] = rd[7:0];
      `CMP(rd[7:0], cal_tab[k])
    end
    // start refused while powered down
    wb(1'b1, ADCS_OFF_CTRL0, 32'h80);
    wb(1'b1, ADCS_OFF_CTRL0, 32'h00);
    repeat (3) @(posedge clk);
    `CMP(busy, 1'b0)
    // conversions over sources, dividers and alignments
    for (int i = 0; i < 9; i++) begin
      v = (i == 0) ? 12'hFFF : (i == 2) ? 12'h514 : 12'($random(seed));
      ch = 4'($random(seed));
      level <= v;
      // power off, configure, then enable and pulse start
      wb(1'b1, ADCS_OFF_CTRL0, 32'h00);
      wb(1'b1, ADCS_OFF_CTRL1, 32'({src_tab[i % 3], 3'(i / 3), 2'(i)}));
      wb(1'b1, ADCS_OFF_CTRL2, 32'({src_tab[i % 3] == ADCS_SRC_TEMP, i[1], 6'h00}));
      wb(1'b1, ADCS_OFF_INTC, 32'h1);
      wb(1'b1, ADCS_OFF_CTRL0, 32'h0A0 | (32'(i[0]) << 4) | 32'(ch));
      wb(1'b1, ADCS_OFF_CTRL0, 32'h020 | (32'(i[0]) << 4) | 32'(ch));
      `CMP(flag, 1'b0)
      `CMP(ana.reference_source_select, 2'(i))
      `CMP(ana.low_current_conv_mode, i[1])
      `CMP(ana.temp_sensor_enable, src_tab[i % 3] == ADCS_SRC_TEMP)
      `CMP(ana.external_channel_select, ch)
      `CMP(ana.route_external, src_tab[i % 3] != ADCS_SRC_TEMP)
      len = 0;
      for (n = 0; n < 2000 && !(len > 0 && busy !== 1'b1); n++) begin
        @(posedge clk);
        if (busy === 1'b1) len++;
      end
      `CMP(len, ((src_tab[i % 3] == ADCS_SRC_TEMP) ? 58 : 16) << (i / 3))
      `CMP(flag, 1'b1)
      wb(1'b0, ADCS_OFF_RES_HI, 32'h0);
      `CMP(rd[7:0], i[0] ? {4'h0, v[11:8]} : v[11:4])
      hi = rd[7:0];
      wb(1'b0, ADCS_OFF_RES_LO, 32'h0);
      `CMP(rd[7:0], i[0] ? v[7:0] : {v[3:0], 4'h0})
      // software temperature from read-back calibration and result
      if (i == 2) begin
        t = ((int'({cal_rd[0], cal_rd[1]}) * int'({hi, rd[7:4]})) >> 12) - int'({cal_rd[2], cal_rd[3][3:0]});
        tx = 12'(t);
        `CMP(tx, 12'hF60)
      end
    end
    summarize();
  end
endmodule : testbench
